// file: core/actuator_pkg.sv
// Constants for the actuator control and status block: frame layout,
// field positions, reset values and timer counts.
// Assumes a 20 MHz system clock and a 24-bit serial frame, MSB first.
`default_nettype none

package actuator_pkg;

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int unsigned FRAME_BITS = 24;
    localparam int unsigned CNT_W      = 5;
    localparam logic [4:0]  FRAME_LEN  = 5'h18;
    localparam int unsigned BIT_SEL    = 0;   // 0: word one, 1: word two

    // ----------------------------------------------------------------
    // Control word two fields
    // ----------------------------------------------------------------
    localparam int unsigned BIT_ENABLE = 23;
    localparam int unsigned BIT_REC_C  = 22;
    localparam int unsigned BIT_REC_B  = 20;
    localparam int unsigned BIT_REC_A  = 19;

    // ----------------------------------------------------------------
    // Control word one fields used here
    // ----------------------------------------------------------------
    localparam int unsigned BIT_CLEAR  = 22;
    localparam int unsigned BIT_DUTY   = 21;
    localparam int unsigned BIT_ON_C   = 17;
    localparam int unsigned BIT_ON_B   = 15;
    localparam int unsigned BIT_ON_A   = 14;

    // ----------------------------------------------------------------
    // Status word fields
    // ----------------------------------------------------------------
    localparam int unsigned ST_MARK    = 23;
    localparam int unsigned ST_OV      = 22;
    localparam int unsigned ST_UV      = 21;
    localparam int unsigned ST_TSD     = 20;
    localparam int unsigned ST_TW      = 19;
    localparam int unsigned ST_NRDY    = 18;
    localparam int unsigned ST_NOERR   = 0;

    localparam logic [23:0] CTRL_RESET = 24'h000000;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned TICK_NS       = 1000;
    localparam int unsigned TICK_CYC      =
        (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STARTUP_US    = 100;
    localparam int unsigned REC_LONG_US   = 400;
    localparam int unsigned REC_SHORT_US  = 100;
    localparam int unsigned STARTUP_TICKS = STARTUP_US * 1000 / TICK_NS;
    localparam int unsigned REC_LONG_TICKS  = REC_LONG_US * 1000 / TICK_NS;
    localparam int unsigned REC_SHORT_TICKS = REC_SHORT_US * 1000 / TICK_NS;
    localparam int unsigned TIMER_W       = 10;
    localparam int unsigned DIV_W         = 5;

    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_SETTLE  = 2'b01,
        MODE_RUN     = 2'b10
    } mode_type;

endpackage

`default_nettype wire

// file: core/sync2.sv
// Two-stage synchroniser for a group of unrelated single-bit levels.
// Assumes each bit is a slow level or is sampled well above its rate.
`default_nettype none

module sync2 #(
    parameter int unsigned     WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             sys_clk, // System clock.
    input  wire logic             reset,   // Synchronous reset, high.
    input  wire logic [WIDTH-1:0] din,     // Asynchronous inputs.
    output logic      [WIDTH-1:0] dout     // Synchronised outputs.
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] dout_d;

    always_comb begin
        meta_d = reset ? RESET_VAL : din;
        dout_d = reset ? RESET_VAL : meta_q;
    end

    always_ff @(posedge sys_clk) begin
        meta_q <= meta_d;
        dout   <= dout_d;
    end

endmodule // sync2

`default_nettype wire

// file: core/actuator_ctrl_status_upper_bits.sv
// Serial control and status logic for the upper fields of the first and the second
// control and status words of a door actuator driver.
// Assumes the serial link (mode 0, MSB first) and all fault detectors
// are asynchronous to sys_clk and slow next to it.
`default_nettype none

module actuator_ctrl_status_upper_bits #(
    parameter int unsigned STARTUP_TICKS = actuator_pkg::STARTUP_TICKS,
    parameter int unsigned REC_LONG      = actuator_pkg::REC_LONG_TICKS,
    parameter int unsigned REC_SHORT     = actuator_pkg::REC_SHORT_TICKS
) (
    input  wire logic sys_clk,           // System clock, 20 MHz.
    input  wire logic reset,             // Synchronous reset, high.
    input  wire logic spi_sclk,          // Serial clock from host.
    input  wire logic spi_cs_n,          // Frame select, low active.
    input  wire logic spi_mosi,          // Serial data in.
    input  wire logic oc_a_in,           // Over-current, output a.
    input  wire logic oc_b_in,           // Over-current, output b.
    input  wire logic oc_c_in,           // Over-current, output c.
    input  wire logic overvoltage_in,    // Supply rail too high.
    input  wire logic undervoltage_in,   // Supply rail too low.
    input  wire logic overtemp_in,       // Thermal shutdown level.
    input  wire logic temp_warn_in,      // Temperature warning level.
    output logic      spi_miso,          // Serial data out.
    output logic      spi_miso_oe,       // Drives miso while selected.
    output logic      highside_output_a, // Highside driver a on.
    output logic      highside_output_b, // Highside driver b on.
    output logic      highside_output_c  // Highside driver c on.
);

    // ----------------------------------------------------------------
    // Input synchronisation and edge detection
    // ----------------------------------------------------------------
    logic [9:0] sync_w;
    logic [2:0] link_prev_q;
    logic [2:0] link_prev_d;
    logic [2:0] oc_prev_q;
    logic [2:0] oc_prev_d;

    sync2 #(
        .WIDTH     (10),
        .RESET_VAL (10'h002)
    ) u_sync (
        .sys_clk (sys_clk),
        .reset   (reset),
        .din     ({temp_warn_in, overtemp_in, undervoltage_in,
                   overvoltage_in, oc_c_in, oc_b_in, oc_a_in,
                   spi_mosi, spi_cs_n, spi_sclk}),
        .dout    (sync_w)
    );

    logic sclk_s, cs_n_s, mosi_s, ov_s, uv_s, tsd_s, tw_s;
    logic [2:0] oc_s;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise;
    logic [2:0] oc_evt;

    always_comb begin
        sclk_s      = sync_w[0];
        cs_n_s      = sync_w[1];
        mosi_s      = sync_w[2];
        oc_s        = sync_w[5:3];
        ov_s        = sync_w[6];
        uv_s        = sync_w[7];
        tsd_s       = sync_w[8];
        tw_s        = sync_w[9];
        sclk_rise   = sclk_s & ~link_prev_q[0] & ~cs_n_s;
        sclk_fall   = ~sclk_s & link_prev_q[0] & ~cs_n_s;
        cs_fall     = ~cs_n_s & link_prev_q[1];
        cs_rise     = cs_n_s & ~link_prev_q[1];
        oc_evt      = oc_s & ~oc_prev_q;
        link_prev_d = reset ? 3'h2 : {1'b0, cs_n_s, sclk_s};
        oc_prev_d   = reset ? 3'h0 : oc_s;
    end

    always_ff @(posedge sys_clk) begin
        link_prev_q <= link_prev_d;
        oc_prev_q   <= oc_prev_d;
    end

    // ----------------------------------------------------------------
    // Status words
    // ----------------------------------------------------------------
    logic [23:0] ctrl_one_q, ctrl_one_d, ctrl_two_q, ctrl_two_d;
    logic [2:0]  oc_flag_q, oc_flag_d;
    logic        tsd_q, tsd_d, tw_q, tw_d;
    actuator_pkg::mode_type mode_q, mode_d;
    logic [23:0] status_one_w, status_two_w;
    logic        noerr_w;

    // The no-error bit spans both words, so it is built once here.
    function automatic logic [23:0] word_two(input logic nrdy);
        logic [23:0] w;
        w = 24'h000000;
        w[actuator_pkg::ST_MARK] = 1'b1;
        w[actuator_pkg::ST_OV]   = ov_s;
        w[actuator_pkg::ST_UV]   = uv_s;
        w[actuator_pkg::ST_TSD]  = tsd_q;
        w[actuator_pkg::ST_TW]   = tw_q;
        w[actuator_pkg::ST_NRDY] = nrdy;
        return w;
    endfunction

    always_comb begin
        status_one_w = 24'h000000;
        status_one_w[actuator_pkg::BIT_ON_A] = oc_flag_q[0];
        status_one_w[actuator_pkg::BIT_ON_B] = oc_flag_q[1];
        status_one_w[actuator_pkg::BIT_ON_C] = oc_flag_q[2];
        status_two_w = word_two(mode_q == actuator_pkg::MODE_SETTLE);
        noerr_w = ~(|status_one_w[22:1] | |status_two_w[22:1]);
        status_one_w[actuator_pkg::ST_NOERR] = noerr_w;
        status_two_w[actuator_pkg::ST_NOERR] = noerr_w;
    end

    // ----------------------------------------------------------------
    // Serial frame engine
    // ----------------------------------------------------------------
    logic [23:0] shift_in_q, shift_in_d, shift_out_q, shift_out_d;
    logic [4:0]  bitcnt_q, bitcnt_d;
    logic        sel_prev_q, sel_prev_d, miso_d, miso_oe_d;
    logic        commit, commit_one, commit_two, clear_cmd;

    always_comb begin
        shift_in_d  = shift_in_q;
        shift_out_d = shift_out_q;
        bitcnt_d    = bitcnt_q;
        sel_prev_d  = sel_prev_q;
        commit      = cs_rise && (bitcnt_q == actuator_pkg::FRAME_LEN);
        commit_two  = commit && shift_in_q[actuator_pkg::BIT_SEL];
        commit_one  = commit && !shift_in_q[actuator_pkg::BIT_SEL];
        if (cs_fall) begin
            bitcnt_d    = 5'h00;
            shift_out_d = sel_prev_q ? status_two_w : status_one_w;
        end else if (sclk_rise) begin
            shift_in_d = {shift_in_q[22:0], mosi_s};
            if (bitcnt_q != 5'h1F) begin
                bitcnt_d = bitcnt_q + 5'h01;
            end
        end else if (sclk_fall) begin
            shift_out_d = {shift_out_q[22:0], 1'b0};
        end
        if (commit) begin
            sel_prev_d = shift_in_q[actuator_pkg::BIT_SEL];
        end
        if (reset) begin
            shift_in_d  = 24'h000000;
            shift_out_d = 24'h000000;
            bitcnt_d    = 5'h00;
            sel_prev_d  = 1'b1;
        end
        miso_d    = shift_out_d[23];
        miso_oe_d = ~reset & ~cs_n_s;
    end

    always_ff @(posedge sys_clk) begin
        shift_in_q  <= shift_in_d;
        shift_out_q <= shift_out_d;
        bitcnt_q    <= bitcnt_d;
        sel_prev_q  <= sel_prev_d;
        spi_miso    <= miso_d;
        spi_miso_oe <= miso_oe_d;
    end

    // ----------------------------------------------------------------
    // Mode, control words and start-up timer
    // ----------------------------------------------------------------
    logic [actuator_pkg::DIV_W-1:0]   div_q, div_d;
    logic [actuator_pkg::TIMER_W-1:0] timer_q, timer_d;
    logic tick;

    always_comb begin
        tick       = (div_q == actuator_pkg::DIV_W'(actuator_pkg::TICK_CYC - 1));
        div_d      = tick ? '0 : div_q + 1'b1;
        ctrl_one_d = ctrl_one_q;
        ctrl_two_d = ctrl_two_q;
        mode_d     = mode_q;
        timer_d    = timer_q;
        clear_cmd  = commit_one && shift_in_q[actuator_pkg::BIT_CLEAR];
        if (mode_q == actuator_pkg::MODE_SETTLE && tick) begin
            if (timer_q == '0) begin
                mode_d = actuator_pkg::MODE_RUN;
            end else begin
                timer_d = timer_q - 1'b1;
            end
        end
        if (commit_two) begin
            if (shift_in_q[actuator_pkg::BIT_ENABLE]) begin
                ctrl_two_d = shift_in_q;
                if (mode_q == actuator_pkg::MODE_STANDBY) begin
                    mode_d  = actuator_pkg::MODE_SETTLE;
                    timer_d = actuator_pkg::TIMER_W'(STARTUP_TICKS);
                end
            end else begin
                mode_d     = actuator_pkg::MODE_STANDBY;
                ctrl_one_d = actuator_pkg::CTRL_RESET;
                ctrl_two_d = actuator_pkg::CTRL_RESET;
            end
        end else if (commit_one && mode_q != actuator_pkg::MODE_STANDBY) begin
            ctrl_one_d = shift_in_q;
            ctrl_one_d[actuator_pkg::BIT_CLEAR] = 1'b0;
        end
        if (reset) begin
            div_d      = '0;
            ctrl_one_d = actuator_pkg::CTRL_RESET;
            ctrl_two_d = actuator_pkg::CTRL_RESET;
            mode_d     = actuator_pkg::MODE_STANDBY;
            timer_d    = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        div_q      <= div_d;
        ctrl_one_q <= ctrl_one_d;
        ctrl_two_q <= ctrl_two_d;
        mode_q     <= mode_d;
        timer_q    <= timer_d;
    end

    // ----------------------------------------------------------------
    // Fault flags and over-current recovery
    // ----------------------------------------------------------------
    logic [2:0] oc_off_q, oc_off_d, rec_arm_q, rec_arm_d, rec_en, expire;
    logic [actuator_pkg::TIMER_W-1:0] rec_cnt_q [3];
    logic [actuator_pkg::TIMER_W-1:0] rec_cnt_d [3];
    logic [actuator_pkg::TIMER_W-1:0] off_time;

    always_comb begin
        rec_en = {ctrl_two_q[actuator_pkg::BIT_REC_C],
                  ctrl_two_q[actuator_pkg::BIT_REC_B],
                  ctrl_two_q[actuator_pkg::BIT_REC_A]};
        off_time = ctrl_one_q[actuator_pkg::BIT_DUTY]
                 ? actuator_pkg::TIMER_W'(REC_SHORT)
                 : actuator_pkg::TIMER_W'(REC_LONG);
        // Set wins over clear on every sticky flag.
        tsd_d = (tsd_q & ~clear_cmd) | tsd_s;
        tw_d  = (tw_q & ~clear_cmd) | tw_s;
        for (int i = 0; i < 3; i++) begin
            expire[i]    = oc_off_q[i] && tick && rec_cnt_q[i] == '0;
            rec_cnt_d[i] = (tick && rec_cnt_q[i] != '0)
                         ? rec_cnt_q[i] - 1'b1 : rec_cnt_q[i];
            oc_flag_d[i] = (oc_flag_q[i] & ~clear_cmd) | oc_evt[i];
            oc_off_d[i]  = oc_off_q[i];
            rec_arm_d[i] = rec_arm_q[i];
            if (clear_cmd || (expire[i] && rec_arm_q[i])) begin
                oc_off_d[i] = 1'b0;
            end
            if (oc_evt[i]) begin
                oc_off_d[i]  = 1'b1;
                rec_cnt_d[i] = off_time;
                // The arm is caught at the event, so one retry still
                // runs if the enable drops while the output rests.
                rec_arm_d[i] = rec_en[i];
            end
            if (reset) begin
                rec_cnt_d[i] = '0;
            end
        end
        if (reset) begin
            tsd_d     = 1'b0;
            tw_d      = 1'b0;
            oc_flag_d = 3'h0;
            oc_off_d  = 3'h0;
            rec_arm_d = 3'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        tsd_q     <= tsd_d;
        tw_q      <= tw_d;
        oc_flag_q <= oc_flag_d;
        oc_off_q  <= oc_off_d;
        rec_arm_q <= rec_arm_d;
        rec_cnt_q <= rec_cnt_d;
    end

    // ----------------------------------------------------------------
    // Output drivers
    // ----------------------------------------------------------------
    logic [2:0] hs_d, on_req;

    always_comb begin
        on_req = {ctrl_one_q[actuator_pkg::BIT_ON_C],
                  ctrl_one_q[actuator_pkg::BIT_ON_B],
                  ctrl_one_q[actuator_pkg::BIT_ON_A]};
        // Supply faults gate the level only, so outputs return alone.
        hs_d = on_req & ~oc_off_q
             & {3{mode_q == actuator_pkg::MODE_RUN}}
             & {3{~ov_s & ~uv_s}}
             & {3{~tsd_q}};
        if (reset) begin
            hs_d = 3'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        highside_output_a <= hs_d[0];
        highside_output_b <= hs_d[1];
        highside_output_c <= hs_d[2];
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [2:0] hs_w;
    assign hs_w = {highside_output_c, highside_output_b, highside_output_a};

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_wake;
        commit_two && shift_in_q[actuator_pkg::BIT_ENABLE]
            && mode_q == actuator_pkg::MODE_STANDBY;
    endsequence
    sequence s_oc_a;
        oc_evt[0] ##1 oc_flag_q[0] && oc_off_q[0];
    endsequence

    property p_wake;
        s_wake |=> mode_q == actuator_pkg::MODE_SETTLE;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake-up");

    property p_sleep;
        commit_two && !shift_in_q[actuator_pkg::BIT_ENABLE] |=>
            mode_q == actuator_pkg::MODE_STANDBY && ctrl_one_q == '0
            && ctrl_two_q == '0 ##1 hs_w == 3'h0;
    endproperty
    a_sleep: assert property (p_sleep) else $error("no standby");

    property p_boot;
        $fell(reset) |-> mode_q == actuator_pkg::MODE_STANDBY;
    endproperty
    a_boot: assert property (p_boot) else $error("not in standby");

    property p_marker;
        cs_fall && sel_prev_q |=> spi_miso;
    endproperty
    a_marker: assert property (p_marker) else $error("marker lost");

    property p_oc;
        s_oc_a |=> !highside_output_a;
    endproperty
    a_oc: assert property (p_oc) else $error("oc not off");

    property p_retry;
        expire[0] && rec_arm_q[0] && !oc_evt[0] |=> !oc_off_q[0];
    endproperty
    a_retry: assert property (p_retry) else $error("no retry");

    property p_hold_off;
        oc_off_q[0] && !expire[0] && !clear_cmd |=> oc_off_q[0];
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("early on");

    property p_supply;
        ov_s || uv_s |=> hs_w == 3'h0;
    endproperty
    a_supply: assert property (p_supply) else $error("supply");

    property p_tsd;
        tsd_q && !clear_cmd |=> tsd_q && hs_w == 3'h0;
    endproperty
    a_tsd: assert property (p_tsd) else $error("tsd released");

    property p_tw;
        tw_q && !clear_cmd |=> tw_q;
    endproperty
    a_tw: assert property (p_tw) else $error("tw dropped");

    property p_settle;
        s_wake |=> (hs_w == 3'h0 && status_two_w[actuator_pkg::ST_NRDY])[*8];
    endproperty
    a_settle: assert property (p_settle) else $error("settle");

    property p_noerr;
        tsd_q || tw_q || (|oc_flag_q) |-> !noerr_w;
    endproperty
    a_noerr: assert property (p_noerr) else $error("noerr");

    property p_frame;
        cs_rise && bitcnt_q != actuator_pkg::FRAME_LEN |=>
            $stable(ctrl_two_q) && $stable(ctrl_one_q);
    endproperty
    a_frame: assert property (p_frame) else $error("bad frame");

endmodule // actuator_ctrl_status_upper_bits

`default_nettype wire

// file: test/host_master_model.sv
// Host serial master model: 24-bit frames, mode 0, MSB first.
// Assumes sys_clk at 20 MHz; sclk half period of eight clocks.
`default_nettype none
module host_master_model (
    input  wire logic sys_clk,  // System clock.
    input  wire logic spi_miso, // Data from device.
    output logic      spi_sclk, // Serial clock.
    output logic      spi_cs_n, // Frame select.
    output logic      spi_mosi  // Data to device.
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // A released data line toggles so a stale bit never looks valid.
    always @(posedge sys_clk) begin
        if (spi_cs_n) begin
            spi_mosi <= ~spi_mosi;
        end
    end
    task automatic xfer(input logic [23:0] tx, input int nbits,
                        output logic [23:0] rx);
        spi_cs_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        for (int i = 23; i >= 24 - nbits; i--) begin
            spi_mosi <= tx[i];
            repeat (8) @(posedge sys_clk);
            spi_sclk <= 1'b1;
            rx[i] = spi_miso;
            repeat (8) @(posedge sys_clk);
            spi_sclk <= 1'b0;
        end
        repeat (8) @(posedge sys_clk);
        spi_cs_n <= 1'b1;
        repeat (12) @(posedge sys_clk);
    endtask
endmodule // host_master_model
`default_nettype wire

// file: test/actuator_ctrl_status_upper_bits_bench.sv
// Self-checking bench for the upper control and status fields.
// Assumes the host model as far side and shortened timer counts.
`default_nettype none
module actuator_ctrl_status_upper_bits_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [23:0] W2  = 24'h800001;
    localparam logic [23:0] W2R = 24'h900001;
    localparam logic [23:0] W1  = 24'h02C000;
    localparam logic [23:0] W1C = 24'h42C000;
    logic        sys_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    logic [2:0]  oc      = 3'h0;
    logic        ov      = 1'b0;
    logic        uv      = 1'b0;
    logic        ot      = 1'b0;
    logic        tw      = 1'b0;
    logic [2:0]  hs;
    logic [23:0] rx;
    int          errors  = 0;
    int          checks_done = 0;
    int          cycles  = 0;
    always #25 sys_clk = ~sys_clk;
    actuator_ctrl_status_upper_bits #(.STARTUP_TICKS(30), .REC_LONG(20),
        .REC_SHORT(5)) i_actuator_ctrl_status_upper_bits (
        .sys_clk(sys_clk), .reset(reset), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .oc_a_in(oc[0]),
        .oc_b_in(oc[1]), .oc_c_in(oc[2]), .overvoltage_in(ov),
        .undervoltage_in(uv), .overtemp_in(ot), .temp_warn_in(tw),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .highside_output_a(hs[0]), .highside_output_b(hs[1]),
        .highside_output_c(hs[2]));
    host_master_model i_host_master_model (.sys_clk(sys_clk),
        .spi_miso(spi_miso), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi));
    task automatic chk_stat(input logic [23:0] exp);
        checks_done++;
        if (rx !== exp) begin
            errors++;
            $display("[ERR] status exp %h got %h", exp, rx);
        end
    endtask
    task automatic chk_out(input logic [2:0] exp);
        checks_done++;
        if (hs !== exp) begin
            errors++;
            $display("[ERR] outputs exp %b got %b", exp, hs);
        end
    endtask
    task automatic chk_oe(input logic exp);
        checks_done++;
        if (spi_miso_oe !== exp) begin
            errors++;
            $display("[ERR] miso_oe exp %b got %b", exp, spi_miso_oe);
        end
    endtask
    task automatic summarize();
        if (errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic xf(input logic [23:0] tx);
        i_host_master_model.xfer(tx, 24, rx);
    endtask
    // A frame one bit short, which the device must drop.
    task automatic xs(input logic [23:0] tx);
        i_host_master_model.xfer(tx, 23, rx);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            summarize();
        end
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_start();
        chk_oe(1'b0);
        fork
            xf(W2);
            begin
                wt(20);
                chk_oe(1'b1);
            end
        join
        chk_stat(24'h800001);
        chk_out(3'h0);
        chk_oe(1'b0);
        xf(W1);
        chk_stat(24'h840000);
        chk_out(3'h0);
        wt(250);
        chk_out(3'h7);
        xf(W2);
        chk_stat(24'h000001);
    endtask
    task automatic t_supply();
        for (int i = 0; i < 2; i++) begin
            ov <= (i == 0);
            uv <= (i == 1);
            wt(10);
            chk_out(3'h0);
            xf(W2);
            chk_stat(i == 0 ? 24'hC00000 : 24'hA00000);
            ov <= 1'b0;
            uv <= 1'b0;
            wt(10);
            chk_out(3'h7);
        end
    endtask
    task automatic t_thermal();
        ot <= 1'b1;
        tw <= 1'b1;
        wt(10);
        ot <= 1'b0;
        tw <= 1'b0;
        wt(10);
        chk_out(3'h0);
        xf(W2);
        chk_stat(24'h980000);
        chk_out(3'h0);
        xf(W1C);
        chk_stat(24'h980000);
        chk_out(3'h7);
        xf(W2);
        chk_stat(24'h000001);
    endtask
    task automatic t_overcurrent();
        xf(W2R);
        oc <= 3'h3;
        wt(10);
        oc <= 3'h0;
        chk_out(3'h4);
        wt(500);
        chk_out(3'h6);
        xf(W1);
        chk_stat(24'h800000);
        xf(W1C);
        chk_stat(24'h00C000);
        chk_out(3'h7);
    endtask
    task automatic t_standby();
        xs(24'h000001);
        chk_out(3'h7);
        xf(24'h000001);
        chk_out(3'h0);
        xf(W2);
        wt(700);
        chk_out(3'h0);
    endtask
    initial begin
        wt(16);
        reset <= 1'b0;
        wt(4);
        t_start();
        t_supply();
        t_thermal();
        t_overcurrent();
        t_standby();
        summarize();
    end
endmodule // actuator_ctrl_status_upper_bits_bench
`default_nettype wire
